//--- bench/relay_contact.sv
`timescale 1ns/1ps
module relay_contact (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [1:0] coil, // relay drive
  output logic [1:0] closed // contact state
);
  // contacts follow the coil a cycle late, like a real pickup
  always_ff @(posedge clk or posedge rst) begin
    if (rst) closed <= 2'b00;
    else closed <= coil;
  end
endmodule

//--- bench/relay_output_conditioner_properties.sv
`timescale 1ns/1ps
module relay_cond_checker
  import relay_cond_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [ADDR_W-1:0] addr, // address
  input wire logic [CNT_W-1:0] wrData, // write data
  input wire logic wrEn, // write
  input wire logic rdEn, // read
  input wire logic [CNT_W-1:0] rdData, // read data
  input wire logic [NUM_RELAYS-1:0] cardFitted, // cards
  input wire logic [NUM_RELAYS-1:0] relayDrive // drive
);
  logic s1_q, s2_q, lk_q, dk_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of the card sync, so writes are only tracked when accepted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= cardFitted[0];
      s2_q <= s1_q;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lk_q <= 1'b0;
      dk_q <= 1'b0;
    end else if (wrEn && s2_q && addr == ADDR_SEL3) begin
      lk_q <= wrData inside {16'h0001, 16'h0003, 16'h0004};
      dk_q <= wrData inside {[16'h0001:16'h0004]};
    end
  end
  lock_pol_a: assert property (
    rdEn && addr == ADDR_POL3 && lk_q && s2_q |=> rdData == '0)
    else $error("polarity readback not locked");
  lock_hold_a: assert property (
    rdEn && addr == ADDR_HLD3 && lk_q && s2_q |=> rdData == '0)
    else $error("hold readback not forced");
  lock_delay_a: assert property (
    rdEn && addr == ADDR_DLY3 && dk_q && s2_q |=> rdData == '0)
    else $error("delay readback not forced");
  delay_clamp_a: assert property (
    wrEn && s2_q && addr == ADDR_DLY3 && wrData > ON_DELAY_MAX && !dk_q
    ##2 rdEn && addr == ADDR_DLY3 |=> rdData == ON_DELAY_MAX)
    else $error("delay not clamped");
  hold_clamp_a: assert property (
    wrEn && s2_q && addr == ADDR_HLD3 && wrData > HOLD_MAX && !lk_q
    ##2 rdEn && addr == ADDR_HLD3 |=> rdData == HOLD_MAX)
    else $error("hold not clamped");
  absent_off_a: assert property (
    !cardFitted[0] [*6] |-> !relayDrive[0])
    else $error("relay3 driven without card");
  absent4_off_a: assert property (
    !cardFitted[1] [*6] |-> !relayDrive[1])
    else $error("relay4 driven without card");
  absent_read_a: assert property (
    rdEn && addr < RELAY_STRIDE && !s1_q && !s2_q |=> rdData == '0)
    else $error("absent relay readback not zero");
  read_hold_a: assert property (!rdEn |=> $stable(rdData))
    else $error("read data moved without a read");
  cover property (rdEn && addr == ADDR_POL3 && lk_q);
  cover property ($rose(relayDrive[0]));
  cover property (rdEn && !cardFitted[0]);
endmodule

//--- bench/relay_output_conditioner_tb_top.sv
`timescale 1ns/1ps
module relay_output_conditioner_tb_top;
  import relay_cond_pkg::*;
  logic clk = 0, rst = 1, wrEn = 0, rdEn = 0;
  logic [ADDR_W-1:0] addr = '0;
  logic [CNT_W-1:0] wrData = '0, rdData;
  logic [NUM_SOURCES-1:0] conditions = '0;
  logic [NUM_RELAYS-1:0] cardFitted = 2'h3, relayDrive, closed;
  int failures = 0, check_count = 0, n, s, d;
  relay_output_conditioner #(.TICK_DIV(4)) relay_output_conditioner_i (
    .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
    .rdEn(rdEn), .rdData(rdData), .conditions(conditions),
    .cardFitted(cardFitted), .relayDrive(relayDrive));
  relay_contact relay_contact_i (.clk(clk), .rst(rst), .coil(relayDrive),
    .closed(closed));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic chk(string nm, logic [CNT_W-1:0] e, logic [CNT_W-1:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [CNT_W-1:0] v);
    @(posedge clk);
    addr <= a;
    wrData <= v;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask
  task automatic rc(logic [ADDR_W-1:0] a, logic [CNT_W-1:0] e, string nm);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    @(negedge clk);
    chk(nm, e, rdData);
  endtask
  // sampled on falling edges, so design updates have landed
  task automatic lat(int i, logic lv, int lo, int hi);
    n = 0;
    while (relayDrive[i] !== lv && n <= hi) begin
      @(negedge clk);
      n++;
    end
    chk("latency ok", 16'h1, 16'(n >= lo && n <= hi));
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    n = $urandom(32'h11197086);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 16; a++) rc(4'(a), a == 8 ? 16'h3 : 16'h0, "reset");
    wr(4'hF, 16'h1234);
    rc(4'hF, 16'h0, "unmapped");
    wr(ADDR_DLY3, 16'hFFFF);
    rc(ADDR_DLY3, ON_DELAY_MAX, "delay clamp");
    wr(ADDR_HLD3, 16'h2710);
    rc(ADDR_HLD3, HOLD_MAX, "hold clamp");
    s = 5 + $urandom % 59;
    d = 1 + $urandom % 3;
    wr(ADDR_SEL3, 16'(s));
    wr(ADDR_DLY3, 16'(d));
    wr(ADDR_HLD3, 16'h2);
    @(posedge clk);
    conditions[s] <= 1'b1;
    lat(0, 1'b1, d * 4 - 2, d * 4 + 6);
    @(posedge clk);
    conditions[s] <= 1'b0;
    lat(0, 1'b0, 6, 14);
    // a short pulse must not leave a partly run delay behind
    wr(ADDR_DLY3, 16'h3);
    @(posedge clk);
    conditions[s] <= 1'b1;
    repeat (6) @(posedge clk);
    conditions[s] <= 1'b0;
    repeat (2) @(posedge clk);
    conditions[s] <= 1'b1;
    lat(0, 1'b1, 10, 18);
    @(negedge clk);
    chk("contact", 16'(relayDrive), 16'(closed));
    wr(ADDR_POL3, 16'h1);
    lat(0, 1'b0, 0, 4);
    @(posedge clk);
    conditions[s] <= 1'b0;
    lat(0, 1'b1, 6, 14);
    for (int k = 1; k < 5; k++) begin
      wr(ADDR_SEL3, 16'(k));
      wr(ADDR_DLY3, 16'h64);
      wr(ADDR_HLD3, 16'h64);
      wr(ADDR_POL3, 16'h1);
      rc(ADDR_DLY3, 16'h0, "delay lock");
      rc(ADDR_HLD3, k == 2 ? 16'h64 : 16'h0, "hold lock");
      rc(ADDR_POL3, k == 2 ? 16'h1 : 16'h0, "polarity lock");
      @(posedge clk);
      conditions[k] <= 1'b1;
      lat(0, k != 2, 2, 6);
      @(posedge clk);
      conditions[k] <= 1'b0;
      if (k != 2) lat(0, 1'b0, 2, 6);
    end
    @(posedge clk);
    cardFitted <= 2'b10;
    conditions[4] <= 1'b1;
    repeat (10) @(negedge clk);
    chk("absent drive", 16'h0, 16'(relayDrive[0]));
    rc(ADDR_SEL3, 16'h0, "absent read");
    wr(ADDR_SEL4, 16'h5);
    rc(ADDR_SEL4, 16'h5, "relay4 select");
    @(posedge clk);
    conditions[5] <= 1'b1;
    lat(1, 1'b1, 2, 6);
    @(posedge clk);
    conditions[5] <= 1'b0;
    lat(1, 1'b0, 2, 6);
    conclude();
  end
endmodule
bind relay_output_conditioner relay_cond_checker relay_cond_checker_i (
  .clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
  .rdEn(rdEn), .rdData(rdData), .cardFitted(cardFitted),
  .relayDrive(relayDrive));

//--- include/relay_cond_pkg.sv
package relay_cond_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] ON_DELAY_MAX = 16'hEA60; // 60000 ms
  localparam logic [CNT_W-1:0] HOLD_MAX = 16'h270F; // 9999 ms
  localparam logic [CNT_W-1:0] TIME_RESET = 16'h0000;
  localparam int NUM_RELAYS = 2;

  // ------------------------------------------------------------
  // register map (relay3 at index 0, relay4 at index 1)
  // ------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_SEL3 = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_DLY3 = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_HLD3 = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_POL3 = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_SEL4 = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_DLY4 = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_HLD4 = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_POL4 = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] RELAY_STRIDE = 4'h4;

  // ------------------------------------------------------------
  // condition selection codes
  // ------------------------------------------------------------
  localparam int SEL_W = 6;
  localparam logic [SEL_W-1:0] SEL_NONE = 6'h00;
  localparam logic [SEL_W-1:0] SEL_NO_FAULT = 6'h01;
  localparam logic [SEL_W-1:0] OUTPUT_CONTACTOR_SELECTION = 6'h02;
  localparam logic [SEL_W-1:0] PRECHARGE_CONTACTOR_SELECTION = 6'h03;
  localparam logic [SEL_W-1:0] LINE_CONTACTOR_SELECTION = 6'h04;
  localparam int NUM_SOURCES = 64;

  typedef struct packed {
    logic [SEL_W-1:0] sel;
    logic [CNT_W-1:0] onDelay;
    logic [CNT_W-1:0] holdTime;
    logic activeLowPolarity;
  } relay_cfg_t;

  localparam relay_cfg_t CFG_RESET = '{SEL_NONE, TIME_RESET,
                                       TIME_RESET, 1'b0};

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_DELAY = 2'b01,
    ST_ON = 2'b11,
    ST_HOLD = 2'b10
  } relay_state_t;
endpackage

//--- src/relay_channel.sv
`timescale 1ns/1ps
module relay_channel
  import relay_cond_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic msTick, // one-cycle 1 ms enable
  input wire logic present, // extension card fitted
  input wire logic cond, // selected condition
  input wire relay_cond_pkg::relay_cfg_t cfg, // effective settings
  output logic relayOut, // relay drive, registered
  output logic active // condition state after timing
);
  relay_state_t state_q;
  logic [CNT_W-1:0] cnt_q;

  // ------------------------------------------------------------
  // on-delay / hold sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_OFF;
      cnt_q <= TIME_RESET;
    end else if (!present) begin
      state_q <= ST_OFF;
      cnt_q <= TIME_RESET;
    end else begin
      case (state_q)
        ST_OFF: begin
          cnt_q <= TIME_RESET;
          if (cond) begin
            state_q <= (cfg.onDelay == TIME_RESET) ? ST_ON : ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (!cond) begin
            state_q <= ST_OFF;
            cnt_q <= TIME_RESET;
          end else if (msTick) begin
            if (cnt_q + 16'h0001 >= cfg.onDelay) begin
              state_q <= ST_ON;
              cnt_q <= TIME_RESET;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
        end
        ST_ON: begin
          cnt_q <= TIME_RESET;
          if (!cond) begin
            state_q <= (cfg.holdTime == TIME_RESET) ? ST_OFF : ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cond) begin
            state_q <= ST_ON;
            cnt_q <= TIME_RESET;
          end else if (msTick) begin
            if (cnt_q + 16'h0001 >= cfg.holdTime) begin
              state_q <= ST_OFF;
              cnt_q <= TIME_RESET;
            end else begin
              cnt_q <= cnt_q + 16'h0001;
            end
          end
        end
        default: begin
          state_q <= ST_OFF;
          cnt_q <= TIME_RESET;
        end
      endcase
    end
  end

  assign active = (state_q == ST_ON) || (state_q == ST_HOLD);

  // relay de-energised when card absent, regardless of polarity
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      relayOut <= 1'b0;
    end else begin
      relayOut <= present & (active ^ cfg.activeLowPolarity);
    end
  end
endmodule

//--- src/relay_output_conditioner.sv
`timescale 1ns/1ps
// Overview of operation
// - relays exist only with card fitted
// - selection same as relay two, default none
// - on-delay 0..60000 ms before turning on
// - hold 0..9999 ms before turning off
// - polarity picks state while condition true
// - contactor/no-fault selections force zero on-delay
// - no-fault/precharge/line selections force zero hold
// - those selections lock polarity, refuse change
module relay_output_conditioner
  import relay_cond_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES // cycles per 1 ms tick
)(
  input wire logic clk, // 10 MHz clock
  input wire logic rst, // async reset, high
  input wire logic [ADDR_W-1:0] addr, // register address
  input wire logic [CNT_W-1:0] wrData, // write data
  input wire logic wrEn, // write strobe
  input wire logic rdEn, // read strobe
  output logic [CNT_W-1:0] rdData, // read data, next cycle
  input wire logic [NUM_SOURCES-1:0] conditions, // internal status
  input wire logic [NUM_RELAYS-1:0] cardFitted, // option cards, pins
  output logic [NUM_RELAYS-1:0] relayDrive // relay 3 and 4 drive
);
  import relay_cond_pkg::*;

  // forces: includes output contactor, do not
  function automatic logic forcedOnDelay(input logic [SEL_W-1:0] s);
    return s == SEL_NO_FAULT || s == OUTPUT_CONTACTOR_SELECTION ||
           s == PRECHARGE_CONTACTOR_SELECTION ||
           s == LINE_CONTACTOR_SELECTION;
  endfunction

  function automatic logic lockedSel(input logic [SEL_W-1:0] s);
    return s == SEL_NO_FAULT || s == PRECHARGE_CONTACTOR_SELECTION ||
           s == LINE_CONTACTOR_SELECTION;
  endfunction

  function automatic logic [CNT_W-1:0] clampTo(input logic [CNT_W-1:0] v,
                                               input logic [CNT_W-1:0] m);
    return (v > m) ? m : v;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers and tick divider
  // ------------------------------------------------------------
  logic [NUM_RELAYS-1:0] fitMeta_q, fit_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fitMeta_q <= '0;
      fit_q <= '0;
    end else begin
      fitMeta_q <= cardFitted;
      fit_q <= fitMeta_q;
    end
  end

  logic [23:0] div_q;
  logic msTick_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      msTick_q <= 1'b0;
    end else if (div_q == 24'(TICK_DIV - 1)) begin
      div_q <= '0;
      msTick_q <= 1'b1;
    end else begin
      div_q <= div_q + 24'h000001;
      msTick_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // configuration registers and channels
  // ------------------------------------------------------------
  relay_cfg_t cfg_q [NUM_RELAYS];
  relay_cfg_t effCfg [NUM_RELAYS];
  logic [NUM_RELAYS-1:0] active;

  genvar g;
  generate
    for (g = 0; g < NUM_RELAYS; g++) begin : gRelay
      localparam logic [ADDR_W-1:0] BASE = ADDR_W'(g) * RELAY_STRIDE;
      logic hit;
      assign hit = wrEn && fit_q[g];

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cfg_q[g] <= CFG_RESET;
        end else if (hit) begin
          if (addr == BASE + ADDR_SEL3) begin
            cfg_q[g].sel <= wrData[SEL_W-1:0];
            if (lockedSel(wrData[SEL_W-1:0])) begin
              cfg_q[g].activeLowPolarity <= 1'b0;
            end
          end else if (addr == BASE + ADDR_DLY3) begin
            cfg_q[g].onDelay <= clampTo(wrData, ON_DELAY_MAX);
          end else if (addr == BASE + ADDR_HLD3) begin
            cfg_q[g].holdTime <= clampTo(wrData, HOLD_MAX);
          end else if (addr == BASE + ADDR_POL3 &&
                       !lockedSel(cfg_q[g].sel)) begin
            cfg_q[g].activeLowPolarity <= wrData[0];
          end
        end
      end

      always_comb begin
        effCfg[g] = cfg_q[g];
        if (forcedOnDelay(cfg_q[g].sel)) begin
          effCfg[g].onDelay = TIME_RESET;
        end
        if (lockedSel(cfg_q[g].sel)) begin
          effCfg[g].holdTime = TIME_RESET;
          effCfg[g].activeLowPolarity = 1'b0;
        end
      end

      logic cond;
      assign cond = (cfg_q[g].sel != SEL_NONE) && conditions[cfg_q[g].sel];

      relay_channel uChan (
        .clk(clk),
        .rst(rst),
        .msTick(msTick_q),
        .present(fit_q[g]),
        .cond(cond),
        .cfg(effCfg[g]),
        .relayOut(relayDrive[g]),
        .active(active[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // read port: effective values shown, absent relays read zero
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= '0;
      for (int i = 0; i < NUM_RELAYS; i++) begin
        if (fit_q[i]) begin
          if (addr == ADDR_W'(i) * RELAY_STRIDE + ADDR_SEL3) begin
            rdData <= CNT_W'(effCfg[i].sel);
          end
          if (addr == ADDR_W'(i) * RELAY_STRIDE + ADDR_DLY3) begin
            rdData <= effCfg[i].onDelay;
          end
          if (addr == ADDR_W'(i) * RELAY_STRIDE + ADDR_HLD3) begin
            rdData <= effCfg[i].holdTime;
          end
          if (addr == ADDR_W'(i) * RELAY_STRIDE + ADDR_POL3) begin
            rdData <= CNT_W'(effCfg[i].activeLowPolarity);
          end
        end
      end
      if (addr == ADDR_STAT) begin
        rdData <= CNT_W'({relayDrive, active, fit_q});
      end
    end
  end
endmodule
